/* File: verilog/tcu_pkg.sv */
// Purpose: Shared constants for the timer capture unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register offsets are byte addresses
package tcu_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] UNIT_CONTROL_OFS   = 8'h00;  // unit_control
  localparam logic [7:0] CAPTURE_VALUE_OFS  = 8'h04;  // capture_value_high:low
  localparam logic [7:0] PERIPH_FLAG_OFS    = 8'h08;  // peripheral_flag_reg_one
  localparam logic [7:0] PERIPH_ENABLE_OFS  = 8'h0c;  // peripheral_enable_reg_one
  localparam logic [7:0] PIN_CONFIG_OFS     = 8'h10;  // pin_direction, alternate_pin_select
  localparam logic [7:0] IRQ_STATUS_OFS     = 8'h14;  // sticky, read to clear
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h18;

  // ----------------------------------------------------------------
  // Fields and widths
  // ----------------------------------------------------------------
  localparam int          MODE_W            = 4;
  localparam int          CAP_W             = 16;
  localparam int          BYTE_W            = 8;
  localparam int          PSC_W             = 4;
  localparam int          IRQ_W             = 2;
  localparam int          IRQ_CAPTURE_BIT   = 0;
  localparam int          IRQ_MODECHG_BIT   = 1;
  localparam int          FLAG_CAPTURE_BIT  = 0;
  localparam int          PIN_DIR_BIT       = 0;
  localparam int          PIN_ALT_BIT       = 1;

  // ----------------------------------------------------------------
  // Mode select codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  MODE_OFF          = 4'h0;
  localparam logic [3:0]  MODE_CAP_FALL     = 4'h4;
  localparam logic [3:0]  MODE_CAP_RISE     = 4'h5;
  localparam logic [3:0]  MODE_CAP_RISE4    = 4'h6;
  localparam logic [3:0]  MODE_CAP_RISE16   = 4'h7;
  localparam logic [3:0]  PSC_LAST4         = 4'h3;
  localparam logic [3:0]  PSC_LAST16        = 4'hf;
  localparam logic [3:0]  PSC_ONE           = 4'h1;
  localparam logic [1:0]  PIN_CONFIG_RST    = 2'h1;  // input, default pin

endpackage

/* File: verilog/tcu_edge_if.sv */
// Purpose: Carries synchronised pin edges from the detector to the core
// Assumes: Single pclk domain
// Notes:   Pulses last one cycle
`timescale 1ns/100ps
interface tcu_edge_if;
  logic rise;
  logic fall;
  modport det  (output rise, output fall);
  modport core (input rise, input fall);
endinterface

/* File: verilog/tcu_edge_det.sv */
// Purpose: Synchronise the capture pin and detect its edges
// Assumes: Pin level is asynchronous to pclk
// Notes:   First flop is read only by the second flop
`timescale 1ns/100ps
module tcu_edge_det
(
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Pin side
  input  wire logic  pin_level,
  // Edge pulses
  tcu_edge_if.det    edges
);

  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;

  // ----------------------------------------------------------------
  // Two-flop synchroniser plus one history stage
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_sync = {sync_ff[1:0], pin_level};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_ff <= 3'h0;
    else
      sync_ff <= nxt_sync;
  end

  // Edges from the settled stages only
  assign edges.rise = sync_ff[1] & ~sync_ff[2];
  assign edges.fall = ~sync_ff[1] & sync_ff[2];

endmodule

/* File: verilog/tcu_top.sv */
// Purpose: Capture function of a timing unit, APB register slave
// Assumes: pclk 20 MHz; companion timer count arrives on pclk
// Notes:   Compare and PWM modes are not built; their codes act as off
//
// Function
// - Qualified event copies 16-bit timer count
// - Mode picks fall, rise, 4th, 16th rise
// - Capture sets the capture event flag
// - Flag clears only by software zero write
// - New capture overwrites unread stored value
// - Detector samples actual pin level
// - Mode change may raise spurious flag
// - Prescaler held zero when off/not capture
// - Any reset clears prescaler counter
// - Prescaler switch keeps counter unchanged
// - Capture input relocatable by alternate select
// - Capture works while timer runs in sleep
`timescale 1ns/100ps
module tcu_top
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Companion timer count, same clock domain
  input  wire logic [15:0] timer_count,
  // Capture pins, default and alternate location
  input  wire logic        cap_pin_main,
  input  wire logic        cap_pin_alt,
  // Pin driver state
  output logic             pin_out_enable_n,
  output logic             pin_alt_sel,
  // Interrupts
  output logic             capture_irq,
  output logic             irq
);

  localparam int CAP_W = tcu_pkg::CAP_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [tcu_pkg::MODE_W-1:0]  unit_mode_select_ff, nxt_mode;
  logic [CAP_W-1:0]            capture_value_ff, nxt_capture;
  logic                        capture_event_flag_ff, nxt_flag;
  logic                        capture_irq_enable_ff, nxt_irq_en;
  logic [1:0]                  pin_config_ff, nxt_pin_config;
  logic [tcu_pkg::PSC_W-1:0]   psc_ff, nxt_psc;
  logic [tcu_pkg::IRQ_W-1:0]   irq_status_ff, nxt_status;
  logic [tcu_pkg::IRQ_W-1:0]   irq_mask_ff, nxt_mask;
  logic [31:0]                 prdata_ff, nxt_prdata;
  logic                        pready_ff, nxt_pready;
  logic                        pslverr_ff, nxt_pslverr;
  logic                        irq_ff, nxt_irq;
  logic                        cap_irq_ff, nxt_cap_irq;
  logic                        capture_take;
  logic                        mode_change;
  logic                        wr_en, rd_en, addr_ok;

  tcu_edge_if edges ();
  tcu_edge_if edges_main ();
  tcu_edge_if edges_alt ();

  // True for any of the four capture codes
  function automatic logic is_capture(input logic [3:0] m);
    return (m == tcu_pkg::MODE_CAP_FALL) || (m == tcu_pkg::MODE_CAP_RISE) ||
           (m == tcu_pkg::MODE_CAP_RISE4) || (m == tcu_pkg::MODE_CAP_RISE16);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == tcu_pkg::UNIT_CONTROL_OFS) || (a == tcu_pkg::CAPTURE_VALUE_OFS) ||
           (a == tcu_pkg::PERIPH_FLAG_OFS) || (a == tcu_pkg::PERIPH_ENABLE_OFS) ||
           (a == tcu_pkg::PIN_CONFIG_OFS) || (a == tcu_pkg::IRQ_STATUS_OFS) ||
           (a == tcu_pkg::IRQ_MASK_OFS);
  endfunction

  // ----------------------------------------------------------------
  // Pin selection and edge detection
  // ----------------------------------------------------------------
  // Each location has its own synchroniser, so a select change makes no false edge
  tcu_edge_det tcu_edge_det_i
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_level (cap_pin_main),
    .edges     (edges_main.det)
  );

  tcu_edge_det tcu_edge_det_alt_i
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_level (cap_pin_alt),
    .edges     (edges_alt.det)
  );

  // Real pin level is sampled even when driven as output, so port writes can capture
  assign edges.rise = pin_config_ff[tcu_pkg::PIN_ALT_BIT] ? edges_alt.rise : edges_main.rise;
  assign edges.fall = pin_config_ff[tcu_pkg::PIN_ALT_BIT] ? edges_alt.fall : edges_main.fall;

  // ----------------------------------------------------------------
  // Event qualification and prescaler
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_psc      = psc_ff;
    capture_take = 1'b0;
    if (!is_capture(unit_mode_select_ff))
      nxt_psc = '0;
    else
    begin
      case (unit_mode_select_ff)
        tcu_pkg::MODE_CAP_FALL:  capture_take = edges.fall;
        tcu_pkg::MODE_CAP_RISE:  capture_take = edges.rise;
        tcu_pkg::MODE_CAP_RISE4:
        begin
          // Counter is not cleared between prescale settings, so a switch may fire early
          if (edges.rise)
          begin
            capture_take = (psc_ff[1:0] == tcu_pkg::PSC_LAST4[1:0]);
            nxt_psc      = psc_ff + tcu_pkg::PSC_ONE;
          end
        end
        tcu_pkg::MODE_CAP_RISE16:
        begin
          if (edges.rise)
          begin
            capture_take = (psc_ff == tcu_pkg::PSC_LAST16);
            nxt_psc      = psc_ff + tcu_pkg::PSC_ONE;
          end
        end
        default: capture_take = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      psc_ff <= '0;
    else
      psc_ff <= nxt_psc;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Writes land at the edge that completes the access, one cycle after pready rises, as pready falls
  assign wr_en   = psel & penable & pwrite & pready_ff;
  assign rd_en   = psel & penable & ~pwrite & ~pready_ff;
  assign addr_ok = is_mapped(paddr);
  assign mode_change = wr_en && (paddr == tcu_pkg::UNIT_CONTROL_OFS) &&
                       (pwdata[tcu_pkg::MODE_W-1:0] != unit_mode_select_ff);

  // Register next values; hardware set wins over any clear
  always_comb
  begin
    nxt_mode       = unit_mode_select_ff;
    nxt_capture    = capture_value_ff;
    nxt_flag       = capture_event_flag_ff;
    nxt_irq_en     = capture_irq_enable_ff;
    nxt_pin_config = pin_config_ff;
    nxt_status     = irq_status_ff;
    nxt_mask       = irq_mask_ff;
    nxt_prdata     = prdata_ff;
    nxt_pready     = 1'b0;
    nxt_pslverr    = 1'b0;
    if (psel & penable & ~pready_ff)
    begin
      nxt_pready  = 1'b1;
      nxt_pslverr = ~addr_ok;
    end
    if (wr_en)
    begin
      case (paddr)
        tcu_pkg::UNIT_CONTROL_OFS:  nxt_mode = pwdata[tcu_pkg::MODE_W-1:0];
        tcu_pkg::PERIPH_FLAG_OFS:
          if (!pwdata[tcu_pkg::FLAG_CAPTURE_BIT])
            nxt_flag = 1'b0;
        tcu_pkg::PERIPH_ENABLE_OFS: nxt_irq_en = pwdata[tcu_pkg::FLAG_CAPTURE_BIT];
        tcu_pkg::PIN_CONFIG_OFS:    nxt_pin_config = pwdata[1:0];
        tcu_pkg::IRQ_MASK_OFS:      nxt_mask = pwdata[tcu_pkg::IRQ_W-1:0];
        default:                    nxt_mode = unit_mode_select_ff;
      endcase
    end
    if (rd_en)
    begin
      nxt_prdata = 32'h0;
      case (paddr)
        tcu_pkg::UNIT_CONTROL_OFS:  nxt_prdata[tcu_pkg::MODE_W-1:0] = unit_mode_select_ff;
        tcu_pkg::CAPTURE_VALUE_OFS: nxt_prdata[CAP_W-1:0] = capture_value_ff;
        tcu_pkg::PERIPH_FLAG_OFS:   nxt_prdata[tcu_pkg::FLAG_CAPTURE_BIT] = capture_event_flag_ff;
        tcu_pkg::PERIPH_ENABLE_OFS: nxt_prdata[tcu_pkg::FLAG_CAPTURE_BIT] = capture_irq_enable_ff;
        tcu_pkg::PIN_CONFIG_OFS:    nxt_prdata[1:0] = pin_config_ff;
        tcu_pkg::IRQ_STATUS_OFS:
        begin
          nxt_prdata[tcu_pkg::IRQ_W-1:0] = irq_status_ff;
          nxt_status = '0;
        end
        tcu_pkg::IRQ_MASK_OFS:      nxt_prdata[tcu_pkg::IRQ_W-1:0] = irq_mask_ff;
        default:                    nxt_prdata = 32'h0;
      endcase
    end
    // Both bytes latched in one cycle so the pair is always coherent
    if (capture_take)
    begin
      nxt_capture = timer_count;
      nxt_flag    = 1'b1;
      nxt_status[tcu_pkg::IRQ_CAPTURE_BIT] = 1'b1;
    end
    if (mode_change)
      nxt_status[tcu_pkg::IRQ_MODECHG_BIT] = 1'b1;
    nxt_irq     = |(nxt_status & nxt_mask);
    nxt_cap_irq = nxt_flag & nxt_irq_en;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_mode_select_ff   <= tcu_pkg::MODE_OFF;
      capture_value_ff      <= '0;
      capture_event_flag_ff <= 1'b0;
      capture_irq_enable_ff <= 1'b0;
      pin_config_ff         <= tcu_pkg::PIN_CONFIG_RST;
      irq_status_ff         <= '0;
      irq_mask_ff           <= '0;
      prdata_ff             <= 32'h0;
      pready_ff             <= 1'b0;
      pslverr_ff            <= 1'b0;
      irq_ff                <= 1'b0;
      cap_irq_ff            <= 1'b0;
    end
    else
    begin
      unit_mode_select_ff   <= nxt_mode;
      capture_value_ff      <= nxt_capture;
      capture_event_flag_ff <= nxt_flag;
      capture_irq_enable_ff <= nxt_irq_en;
      pin_config_ff         <= nxt_pin_config;
      irq_status_ff         <= nxt_status;
      irq_mask_ff           <= nxt_mask;
      prdata_ff             <= nxt_prdata;
      pready_ff             <= nxt_pready;
      pslverr_ff            <= nxt_pslverr;
      irq_ff                <= nxt_irq;
      cap_irq_ff            <= nxt_cap_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign irq              = irq_ff;
  assign capture_irq      = cap_irq_ff;
  assign pin_out_enable_n = pin_config_ff[tcu_pkg::PIN_DIR_BIT];
  assign pin_alt_sel      = pin_config_ff[tcu_pkg::PIN_ALT_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take;
    capture_take;
  endsequence

  chk_capture_copies_count: assert property (s_take |=> capture_value_ff == $past(timer_count))
    else $error("capture value not copied");
  chk_flag_set_capture: assert property (s_take |=> capture_event_flag_ff)
    else $error("capture flag not set");
  chk_flag_no_self_clear: assert property ($fell(capture_event_flag_ff) |->
      $past(wr_en) && $past(paddr) == tcu_pkg::PERIPH_FLAG_OFS)
    else $error("capture flag cleared without write");
  chk_psc_zero_off: assert property (!is_capture(unit_mode_select_ff) |=> psc_ff == '0)
    else $error("prescaler not held at zero");
  chk_rise_mode_take: assert property (unit_mode_select_ff == tcu_pkg::MODE_CAP_RISE && edges.rise
      |-> capture_take)
    else $error("rising edge not captured");
  chk_fall_mode_take: assert property (unit_mode_select_ff == tcu_pkg::MODE_CAP_FALL
      && capture_take |-> edges.fall)
    else $error("capture without falling edge");
  chk_rise16_count: assert property (unit_mode_select_ff == tcu_pkg::MODE_CAP_RISE16 && capture_take
      |-> psc_ff == tcu_pkg::PSC_LAST16)
    else $error("sixteenth edge count wrong");
  chk_psc_kept_switch: assert property (unit_mode_select_ff == tcu_pkg::MODE_CAP_RISE4 && !edges.rise
      ##1 unit_mode_select_ff == tcu_pkg::MODE_CAP_RISE16 |-> psc_ff == $past(psc_ff))
    else $error("prescaler changed on switch");

  // Mode writes that change the code leave a status mark
  sequence s_mode_write;
    mode_change;
  endsequence

  chk_mode_change_mark: assert property (s_mode_write |=> irq_status_ff[tcu_pkg::IRQ_MODECHG_BIT])
    else $error("mode change not recorded");
  chk_rise4_count: assert property (unit_mode_select_ff == tcu_pkg::MODE_CAP_RISE4 && capture_take
      |-> psc_ff[1:0] == tcu_pkg::PSC_LAST4[1:0])
    else $error("fourth edge count wrong");
  chk_take_needs_mode: assert property (s_take |-> is_capture(unit_mode_select_ff))
    else $error("capture outside capture mode");

endmodule

/* File: tb/tcu_pin_model.sv */
// Purpose: Far side of the capture unit: pin events and companion timer
// Assumes: Pin pulses held 4 pclk per level, timer ticks at pclk/4
// Notes:   Timer can be frozen at a known value for exact capture checks
`timescale 1ns/100ps
module tcu_pin_model
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Pins and timer
  output logic             pin_main,
  output logic             pin_alt,
  output logic [15:0]      timer_count
);
  logic        hold;
  logic [15:0] load_val;
  logic [15:0] cnt;
  logic [1:0]  div;

  initial
  begin
    pin_main = 1'b0;
    pin_alt  = 1'b0;
    hold     = 1'b0;
    load_val = 16'h0000;
  end

  // ----------------------------------------------------------------
  // Timer on instruction clock, synchronous to pclk
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 16'h0000;
      div <= 2'h0;
    end
    else
    begin
      div <= div + 2'h1;
      if (div == 2'h3)
        cnt <= cnt + 16'h0001;
    end
  end

  // Frozen value keeps the expected capture exact
  assign timer_count = hold ? load_val : cnt;

  task automatic set_timer(input logic [15:0] v);
    @(posedge pclk);
    load_val <= v;
    hold     <= 1'b1;
  endtask

  // One pin level, held long enough for the synchroniser
  task automatic level(input logic alt, input logic v);
    @(posedge pclk);
    if (alt)
      pin_alt <= v;
    else
      pin_main <= v;
    repeat (3) @(posedge pclk);
  endtask

  task automatic pulse(input logic alt, input int n);
    repeat (n)
    begin
      level(alt, 1'b1);
      level(alt, 1'b0);
    end
  endtask
endmodule

/* File: tb/tcu_top_test.sv */
// Purpose: Self-checking bench for the capture unit over APB
// Assumes: pclk 20 MHz, one wait state APB slave
// Notes:   Mode is cleared and flag rewritten around every mode change made through set_mode
`timescale 1ns/100ps
module tcu_top_test;
  logic        pclk, presetn, psel, penable, pwrite, lerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, oen_n, alt_sel, capture_irq, irq;
  logic        pin_main, pin_alt;
  logic [15:0] timer_count;
  int          failures, tests_run;
  localparam logic [7:0] CTL = tcu_pkg::UNIT_CONTROL_OFS;
  localparam logic [7:0] FLG = tcu_pkg::PERIPH_FLAG_OFS;

  tcu_top tcu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_count(timer_count), .cap_pin_main(pin_main),
    .cap_pin_alt(pin_alt), .pin_out_enable_n(oen_n), .pin_alt_sel(alt_sel),
    .capture_irq(capture_irq), .irq(irq));
  tcu_pin_model tcu_pin_model_i (.pclk(pclk), .presetn(presetn), .pin_main(pin_main),
    .pin_alt(pin_alt), .timer_count(timer_count));

  // ----------------------------------------------------------------
  // Clock, verdict and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      $display("[ERR] %0t bus timeout", $time);
      finish_test;
    end
    rdat = prdata;
    lerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_mode(input logic [3:0] m);
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, CTL, 32'(m));
    apb(1'b1, FLG, 32'h0);
  endtask

  task automatic flag_is(input logic [31:0] e);
    apb(1'b0, FLG, 32'h0);
    check(rdat & 32'h1, e);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    apb(1'b0, CTL, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, tcu_pkg::PIN_CONFIG_OFS, 32'h0);
    check(rdat, 32'h1);
    check(32'(lerr), 32'h0);
    check(32'(oen_n), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(lerr), 32'h1);
    check(rdat, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_rise_fall;
    set_mode(tcu_pkg::MODE_CAP_RISE);
    tcu_pin_model_i.set_timer(16'h1234);
    tcu_pin_model_i.pulse(1'b0, 1);
    flag_is(32'h1);
    tcu_pin_model_i.set_timer(16'habcd);
    tcu_pin_model_i.pulse(1'b0, 1);
    apb(1'b0, tcu_pkg::CAPTURE_VALUE_OFS, 32'h0);
    check(rdat, 32'h0000abcd);
    apb(1'b1, FLG, 32'h1);
    flag_is(32'h1);
    apb(1'b1, FLG, 32'h0);
    flag_is(32'h0);
    set_mode(tcu_pkg::MODE_CAP_FALL);
    tcu_pin_model_i.set_timer(16'h0f0f);
    tcu_pin_model_i.level(1'b0, 1'b1);
    flag_is(32'h0);
    tcu_pin_model_i.set_timer(16'h5a5a);
    tcu_pin_model_i.level(1'b0, 1'b0);
    apb(1'b0, tcu_pkg::CAPTURE_VALUE_OFS, 32'h0);
    check(rdat, 32'h00005a5a);
    $display("test_rise_fall done");
  endtask

  // Prescaler counts, then a direct 4th to 16th switch keeps the count
  task automatic test_presc;
    for (int i = 0; i < 2; i++)
    begin
      set_mode(i == 0 ? tcu_pkg::MODE_CAP_RISE4 : tcu_pkg::MODE_CAP_RISE16);
      tcu_pin_model_i.pulse(1'b0, i == 0 ? 3 : 15);
      flag_is(32'h0);
      tcu_pin_model_i.pulse(1'b0, 1);
      flag_is(32'h1);
    end
    set_mode(tcu_pkg::MODE_CAP_RISE4);
    tcu_pin_model_i.pulse(1'b0, 2);
    apb(1'b1, CTL, 32'(tcu_pkg::MODE_CAP_RISE16));
    apb(1'b1, FLG, 32'h0);
    tcu_pin_model_i.pulse(1'b0, 13);
    flag_is(32'h0);
    tcu_pin_model_i.pulse(1'b0, 1);
    flag_is(32'h1);
    $display("test_presc done");
  endtask

  // Partial count then unit off or reset: count restarts from zero
  task automatic test_clear(input logic by_reset);
    set_mode(tcu_pkg::MODE_CAP_RISE4);
    tcu_pin_model_i.pulse(1'b0, 2);
    if (by_reset)
    begin
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
    end
    else
    begin
      apb(1'b1, CTL, 32'h0);
      tcu_pin_model_i.pulse(1'b0, 2);
      flag_is(32'h0);
    end
    set_mode(tcu_pkg::MODE_CAP_RISE4);
    tcu_pin_model_i.pulse(1'b0, 3);
    flag_is(32'h0);
    tcu_pin_model_i.pulse(1'b0, 1);
    flag_is(32'h1);
    $display("test_clear done");
  endtask

  task automatic test_irq;
    set_mode(tcu_pkg::MODE_CAP_RISE);
    apb(1'b0, tcu_pkg::IRQ_STATUS_OFS, 32'h0);
    tcu_pin_model_i.pulse(1'b0, 1);
    check(32'(capture_irq), 32'h0);
    apb(1'b1, tcu_pkg::PERIPH_ENABLE_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(capture_irq), 32'h1);
    check(32'(irq), 32'h0);
    apb(1'b1, tcu_pkg::IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h1);
    apb(1'b0, tcu_pkg::IRQ_STATUS_OFS, 32'h0);
    check(rdat & 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    apb(1'b1, FLG, 32'h0);
    repeat (2) @(posedge pclk);
    check(32'(capture_irq), 32'h0);
    apb(1'b1, tcu_pkg::PERIPH_ENABLE_OFS, 32'h0);
    apb(1'b1, CTL, 32'(tcu_pkg::MODE_CAP_FALL));
    apb(1'b0, tcu_pkg::IRQ_STATUS_OFS, 32'h0);
    check(rdat, 32'h2);
    $display("test_irq done");
  endtask

  // Pin as output on the alternate location
  task automatic test_pins;
    apb(1'b1, tcu_pkg::PIN_CONFIG_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    check(32'(oen_n), 32'h0);
    check(32'(alt_sel), 32'h1);
    set_mode(tcu_pkg::MODE_CAP_RISE);
    tcu_pin_model_i.pulse(1'b0, 1);
    flag_is(32'h0);
    tcu_pin_model_i.set_timer(16'h0777);
    tcu_pin_model_i.pulse(1'b1, 1);
    apb(1'b0, tcu_pkg::CAPTURE_VALUE_OFS, 32'h0);
    check(rdat, 32'h00000777);
    $display("test_pins done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_reset;
    test_rise_fall;
    test_presc;
    test_clear(1'b0);
    test_clear(1'b1);
    test_irq;
    test_pins;
    finish_test;
  end

  initial
  begin
    repeat (100000) @(posedge pclk);
    failures++;
    $display("[ERR] %0t run timeout", $time);
    finish_test;
  end
endmodule
